// ### cpmrt_ext_dev.sv
// Partner model: oscillators feeding the block and a user of its clock output
`timescale 1ns/100ps
module cpmrt_ext_dev (
   // Bus clock that times the sampled levels
   input wire logic pclk,
   // Oscillator levels toward the block
   output logic fast_reference_clock,
   output logic slow_crystal_clock,
   // Clock output as seen by the external user
   input wire logic clock_output_pin,
   output int clk_seen
);
   logic [1:0] phase = 2'h0;
   logic co_last = 1'b0;
   initial begin
      fast_reference_clock = 1'b0;
      slow_crystal_clock = 1'b0;
      clk_seen = 0;
   end
   // Crystal is high one cycle in three, below the half rate the sampler follows
   always @(posedge pclk) begin
      fast_reference_clock <= !fast_reference_clock;
      phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      slow_crystal_clock <= (phase == 2'h2);
      co_last <= clock_output_pin;
      clk_seen <= clk_seen + int'(clock_output_pin && !co_last);
   end
endmodule

// ### cpmrt_pkg.sv
// Package: constants for clock, power mode, reset and timer control
package cpmrt_pkg;
   // ------------------------------------------------------------
   // Register byte offsets (APB, one aligned word each)
   // ------------------------------------------------------------
   localparam logic [7:0] CPMRT_CTRL = 8'h00;
   localparam logic [7:0] CPMRT_MODE = 8'h04;
   localparam logic [7:0] CPMRT_RSTS = 8'h08;
   localparam logic [7:0] CPMRT_TSEC = 8'h0c;
   localparam logic [7:0] CPMRT_TFRC = 8'h10;
   localparam logic [7:0] CPMRT_TALM = 8'h14;
   localparam logic [7:0] CPMRT_PCTL = 8'h18;
   localparam logic [7:0] CPMRT_PMOD = 8'h1c;
   localparam logic [7:0] CPMRT_PCNT = 8'h20;
   localparam logic [7:0] CPMRT_WCTL = 8'h24;
   localparam logic [7:0] CPMRT_WSRV = 8'h28;
   localparam logic [7:0] CPMRT_PERI = 8'h2c;
   localparam logic [7:0] CPMRT_DOZE = 8'h30;
   // ------------------------------------------------------------
   // Prescaler taps and service keys
   // ------------------------------------------------------------
   localparam int CPMRT_TOD_DIV = 128;
   localparam int CPMRT_PIT_DIV = 4;
   localparam int CPMRT_WD_DIV = 16384;
   localparam int CPMRT_PRE_W = 14;
   localparam logic [15:0] CPMRT_WKEY1 = 16'h5555;
   localparam logic [15:0] CPMRT_WKEY2 = 16'haaaa;
   localparam logic [5:0] CPMRT_WD_RST = 6'h3f;
   // Low-power mode indicator encodings
   typedef enum logic [1:0] {
      CPMRT_RUN = 2'b00,
      CPMRT_WAIT = 2'b01,
      CPMRT_DOZE_M = 2'b10,
      CPMRT_STOP = 2'b11
   } cpmrt_mode_t;
   // Clock output selections
   localparam logic [1:0] CPMRT_CO_OFF = 2'b00;
   localparam logic [1:0] CPMRT_CO_FAST = 2'b01;
   localparam logic [1:0] CPMRT_CO_SLOW = 2'b10;
endpackage

// ### cpmrt_properties.sv
// Checker: timing relations at the ports of the clock and power mode block
`timescale 1ns/100ps
module cpmrt_properties import cpmrt_pkg::*; #(
   parameter int NPERI = 8
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // Requests and wake sources
   input wire logic [1:0] lp_instr,
   input wire logic lp_instr_valid,
   input wire logic irq_any,
   input wire logic [NPERI-1:0] peri_irq,
   input wire logic low_voltage_reset,
   input wire logic external_reset,
   input wire logic power_on_reset,
   // Block outputs
   input wire logic cpu_clk_en,
   input wire logic slow_tick,
   input wire logic clock_output_pin,
   input wire logic [1:0] power_mode_indicator_pins,
   input wire logic system_reset,
   input wire logic tod_alarm_irq,
   input wire logic pit_irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------
   // Request decode; a pending wake source could cut an entry short
   // ----------------------------------------
   wire [1:0] pm = power_mode_indicator_pins;
   wire quiet = !irq_any && peri_irq == '0 && !tod_alarm_irq && !pit_irq && !system_reset;
   wire req = lp_instr_valid && lp_instr != 2'b00 && pm == CPMRT_RUN && cpu_clk_en && clk_en && quiet;
   AST_ENTER_HALT: assert property (req |-> ##[1:2] !cpu_clk_en)
      else $error("processor clock still running after entry");
   AST_ENTER_PINS: assert property (req |-> ##[1:3] pm == lp_instr)
      else $error("mode pins do not show requested mode");
   AST_WAIT_HOLD: assert property ((pm == CPMRT_WAIT && quiet && clk_en)[*3] |-> !cpu_clk_en)
      else $error("processor woke without a wake source");
   AST_WAIT_WAKE: assert property (pm == CPMRT_WAIT && irq_any && clk_en
      |-> ##[0:2] cpu_clk_en ##[0:2] pm == CPMRT_RUN)
      else $error("interrupt did not wake from wait");
   AST_PIT_WAKE: assert property (pm == CPMRT_STOP && pit_irq && clk_en |-> ##[0:2] cpu_clk_en)
      else $error("periodic timer did not wake from stop");
   AST_STOP_QUIET: assert property (pm == CPMRT_STOP && $past(pm) == CPMRT_STOP && !cpu_clk_en
      |-> !clock_output_pin && !slow_tick)
      else $error("clocks still running in stop");
   AST_RESET_OUT: assert property (low_voltage_reset || external_reset || power_on_reset
      |-> ##[0:1] system_reset)
      else $error("reset source did not raise system reset");
   AST_CLOCK_OUTPUT_PIN_RST: assert property (disable iff (1'b0) !presetn |-> !clock_output_pin)
      else $error("clock output active during reset");
   AST_CLOCK_OUTPUT_PIN_INIT: assert property (disable iff (1'b0) !presetn ##1 presetn |-> !clock_output_pin[*3])
      else $error("clock output active right after reset");
   cover property (req && lp_instr == 2'b11);
   cover property (pm == CPMRT_DOZE_M && !cpu_clk_en);
   cover property (system_reset);
endmodule
bind cpmrt_top cpmrt_properties #(.NPERI(NPERI)) u_props (.pclk(pclk), .presetn(presetn),
   .clk_en(clk_en), .lp_instr(lp_instr), .lp_instr_valid(lp_instr_valid), .irq_any(irq_any),
   .peri_irq(peri_irq), .low_voltage_reset(low_voltage_reset), .external_reset(external_reset),
   .power_on_reset(power_on_reset), .cpu_clk_en(cpu_clk_en), .slow_tick(slow_tick),
   .clock_output_pin(clock_output_pin), .power_mode_indicator_pins(power_mode_indicator_pins),
   .system_reset(system_reset), .tod_alarm_irq(tod_alarm_irq), .pit_irq(pit_irq));

// ### cpmrt_top.sv
// Clock generation, power mode, reset status and timer control block
// Summary of operation
// - Fast reference from pin, slow clock from crystal; both enter here.
// - Peripherals get slow or prescaled slow clock enables, synchronized.
// - Each peripheral clock enable is gated independently of the processor.
// - Clock output selects fast clock, slow clock or off.
// - Four modes drive distinct codes on the mode indicator pins.
// - Run mode enables the processor clock and each peripheral clock set in peri_on.
// - Each power-saving mode starts from its own processor instruction request.
// - Power-saving modes halt the processor until interrupt or reset.
// - Time-of-day timer keeps counting in every mode.
// - Wait halts only the processor clock; any interrupt wakes.
// - Doze keeps peripherals per programmed mask; their interrupts wake.
// - Stop halts most clocks; periodic timer and watchdog optionally run.
// - Peripheral control registers are kept through stop mode.
// - Four reset sources each set their own status bit.
// - Clock output is disabled by reset until software re-enables it.
// - Time-of-day timer advances on slow clock divided by 128.
// - Time-of-day holds 32-bit seconds and 1/256 second fractions.
// - Time-of-day alarm wakes from doze and stop; wait wakes on it only through irq_any.
// - Periodic timer on slow/4, reload or free-run, polled or interrupt.
// - Watchdog on slow/16384 with 6-bit time-out count.
// - Each completed service sequence reloads the watchdog count.
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/100ps
module cpmrt_top #(
   parameter int NPERI = 8
) (
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Clock sources, already sampled in the pclk domain
   input wire logic fast_reference_clock,
   input wire logic slow_crystal_clock,
   // Reset sources
   input wire logic low_voltage_reset,
   input wire logic external_reset,
   input wire logic power_on_reset,
   // Processor interface
   input wire logic [1:0] lp_instr,
   input wire logic lp_instr_valid,
   input wire logic irq_any,
   input wire logic [NPERI-1:0] peri_irq,
   // Outputs
   output logic cpu_clk_en,
   output logic [NPERI-1:0] peri_clk_en,
   output logic slow_tick,
   output logic pre_tick,
   output logic clock_output_pin,
   output logic [1:0] power_mode_indicator_pins,
   output logic system_reset,
   output logic tod_alarm_irq,
   output logic pit_irq
);
   import cpmrt_pkg::*;

   // Enables and masks are read back as one 32-bit word, so wider sets cannot be served
   if (NPERI < 1 || NPERI > 32) begin : g_bad_nperi
      $error("NPERI must be 1..32");
   end

   // ------------------------------------------------------------
   // Slow clock edge detect and prescaler
   // ------------------------------------------------------------
   logic slow_q;
   logic [CPMRT_PRE_W-1:0] pre;
   wire slow_rise = slow_crystal_clock & ~slow_q;
   wire [CPMRT_PRE_W-1:0] pre_next = pre + 1'b1;
   wire tod_tick = slow_rise && pre[6:0] == 7'h7f;
   wire pit_tick = slow_rise && pre[1:0] == 2'h3;
   wire wd_tick = slow_rise && pre == {CPMRT_PRE_W{1'b1}};

   // Synchronized slow edge and prescaler counter, free-running in all modes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slow_q <= 1'b0;
         pre <= '0;
      end else if (clk_en) begin
         slow_q <= slow_crystal_clock;
         if (slow_rise) pre <= pre_next;
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   cpmrt_mode_t mode;
   logic [1:0] co_sel;
   logic [3:0] rst_stat;
   logic [31:0] tod_sec;
   logic [7:0] tod_frac;
   logic [31:0] alm_sec;
   logic alm_en, alm_flag;
   logic pit_en, pit_free, pit_ie, pit_stop_run, pit_flag;
   logic [15:0] pit_mod, pit_cnt;
   logic wd_en, wd_stop_run, wd_key1;
   logic [5:0] wd_load, wd_cnt;
   logic [NPERI-1:0] peri_on, doze_keep;

   wire wr = psel & penable & pwrite & clk_en;
   wire rd_acc = psel & penable & ~pwrite;
   wire known = paddr <= CPMRT_DOZE && paddr[1:0] == 2'b00;
   wire w_ctrl = wr && paddr == CPMRT_CTRL;
   wire w_rsts = wr && paddr == CPMRT_RSTS;
   wire w_tsec = wr && paddr == CPMRT_TSEC;
   wire w_talm = wr && paddr == CPMRT_TALM;
   wire w_pctl = wr && paddr == CPMRT_PCTL;
   wire w_pmod = wr && paddr == CPMRT_PMOD;
   wire w_wctl = wr && paddr == CPMRT_WCTL;
   wire w_wsrv = wr && paddr == CPMRT_WSRV;
   wire w_peri = wr && paddr == CPMRT_PERI;
   wire w_doze = wr && paddr == CPMRT_DOZE;

   // Wake: any interrupt in wait; kept peripheral interrupts in doze; timers in stop
   wire doze_wake = |(peri_irq & doze_keep);
   wire stop_wake = (pit_irq & pit_stop_run) | tod_alarm_irq;
   wire wake = (mode == CPMRT_WAIT && irq_any) ||
               (mode == CPMRT_DOZE_M && (doze_wake || tod_alarm_irq)) ||
               (mode == CPMRT_STOP && stop_wake);
   wire in_stop = mode == CPMRT_STOP;

   // ------------------------------------------------------------
   // Power mode sequencing
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode <= CPMRT_RUN;
      end else if (clk_en) begin
         if (system_reset) begin
            mode <= CPMRT_RUN;
         end else if (mode != CPMRT_RUN) begin
            if (wake) mode <= CPMRT_RUN;
         end else if (lp_instr_valid && lp_instr != CPMRT_RUN) begin
            mode <= cpmrt_mode_t'(lp_instr);
         end
      end
   end

   // Control: clock output select and peripheral enables (kept through stop)
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         co_sel <= CPMRT_CO_OFF;
         peri_on <= '1;
         doze_keep <= '0;
      end else if (clk_en) begin
         if (system_reset) co_sel <= CPMRT_CO_OFF;
         else if (w_ctrl) co_sel <= pwdata[1:0];
         if (w_peri) peri_on <= pwdata[NPERI-1:0];
         if (w_doze) doze_keep <= pwdata[NPERI-1:0];
      end
   end

   // ------------------------------------------------------------
   // Reset source status; software writes ones to clear, set wins
   // ------------------------------------------------------------
   wire wd_expire = wd_en && wd_tick && wd_cnt == 6'h00 &&
                    !(in_stop && !wd_stop_run);
   wire [3:0] rst_src = {wd_expire, power_on_reset, external_reset, low_voltage_reset};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_stat <= 4'h0;
         system_reset <= 1'b0;
      end else if (clk_en) begin
         rst_stat <= (rst_stat & ~({4{w_rsts}} & pwdata[3:0])) | rst_src;
         system_reset <= |rst_src;
      end
   end

   // ------------------------------------------------------------
   // Time-of-day timer with alarm; never gated by mode
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tod_sec <= 32'h0;
         tod_frac <= 8'h00;
         alm_sec <= 32'h0;
         alm_en <= 1'b0;
         alm_flag <= 1'b0;
      end else if (clk_en) begin
         if (w_tsec) begin
            tod_sec <= pwdata;
            tod_frac <= 8'h00;
         end else if (tod_tick) begin
            tod_frac <= tod_frac + 8'h01;
            if (tod_frac == 8'hff) tod_sec <= tod_sec + 32'h1;
         end
         if (w_talm) alm_sec <= pwdata;
         if (w_ctrl) alm_en <= pwdata[4];
         if (alm_en && tod_tick && tod_frac == 8'hff && tod_sec + 32'h1 == alm_sec)
            alm_flag <= 1'b1;
         else if (w_ctrl && pwdata[5]) alm_flag <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Periodic interrupt timer
   // ------------------------------------------------------------
   wire pit_run = pit_en && pit_tick && !(in_stop && !pit_stop_run);
   wire pit_zero = pit_cnt == 16'h0000;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {pit_en, pit_free, pit_ie, pit_stop_run} <= 4'h0;
         pit_mod <= 16'hffff;
         pit_cnt <= 16'hffff;
         pit_flag <= 1'b0;
      end else if (clk_en) begin
         if (w_pctl) {pit_stop_run, pit_ie, pit_free, pit_en} <= pwdata[3:0];
         if (w_pmod) begin
            pit_mod <= pwdata[15:0];
            pit_cnt <= pwdata[15:0];
         end else if (pit_run) begin
            if (pit_zero && !pit_free) pit_cnt <= pit_mod;
            else pit_cnt <= pit_cnt - 16'h0001;
         end
         if (pit_run && pit_zero) pit_flag <= 1'b1;
         else if (w_pctl && pwdata[4]) pit_flag <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Watchdog: two-key service sequence reloads the count
   // ------------------------------------------------------------
   wire wd_serve = w_wsrv && wd_key1 && pwdata[15:0] == CPMRT_WKEY2;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_en <= 1'b0;
         wd_stop_run <= 1'b0;
         wd_load <= CPMRT_WD_RST;
         wd_cnt <= CPMRT_WD_RST;
         wd_key1 <= 1'b0;
      end else if (clk_en) begin
         if (w_wctl) begin
            wd_load <= pwdata[5:0];
            wd_en <= pwdata[8];
            wd_stop_run <= pwdata[9];
         end
         if (w_wsrv) wd_key1 <= pwdata[15:0] == CPMRT_WKEY1;
         if (wd_serve || wd_expire) wd_cnt <= wd_load;
         else if (wd_en && wd_tick && !(in_stop && !wd_stop_run))
            wd_cnt <= wd_cnt - 6'h01;
      end
   end

   // ------------------------------------------------------------
   // Clock enables, pins and read data
   // ------------------------------------------------------------
   wire run_m = mode == CPMRT_RUN;
   wire [NPERI-1:0] next_peri =
      (run_m || mode == CPMRT_WAIT) ? peri_on :
      (mode == CPMRT_DOZE_M) ? (peri_on & doze_keep) : '0;
   wire next_co = co_sel == CPMRT_CO_FAST ? fast_reference_clock :
                  co_sel == CPMRT_CO_SLOW ? slow_crystal_clock : 1'b0;
   logic [31:0] rdmux;
   always_comb begin
      rdmux = 32'h0;
      unique case (paddr)
         CPMRT_CTRL: rdmux = {26'h0, alm_flag, alm_en, 2'h0, co_sel};
         CPMRT_MODE: rdmux = {30'h0, mode};
         CPMRT_RSTS: rdmux = {28'h0, rst_stat};
         CPMRT_TSEC: rdmux = tod_sec;
         CPMRT_TFRC: rdmux = {24'h0, tod_frac};
         CPMRT_TALM: rdmux = alm_sec;
         CPMRT_PCTL: rdmux = {27'h0, pit_flag, pit_stop_run, pit_ie, pit_free, pit_en};
         CPMRT_PMOD: rdmux = {16'h0, pit_mod};
         CPMRT_PCNT: rdmux = {16'h0, pit_cnt};
         CPMRT_WCTL: rdmux = {10'h0, wd_cnt, 6'h0, wd_stop_run, wd_en, 2'h0, wd_load};
         CPMRT_PERI: rdmux = 32'(peri_on);
         CPMRT_DOZE: rdmux = 32'(doze_keep);
         default: rdmux = 32'h0;
      endcase
   end

   // Registered outputs; pready answers in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_clk_en <= 1'b1;
         peri_clk_en <= '1;
         slow_tick <= 1'b0;
         pre_tick <= 1'b0;
         clock_output_pin <= 1'b0;
         power_mode_indicator_pins <= CPMRT_RUN;
         tod_alarm_irq <= 1'b0;
         pit_irq <= 1'b0;
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         cpu_clk_en <= run_m && !(lp_instr_valid && lp_instr != CPMRT_RUN);
         peri_clk_en <= next_peri & {NPERI{~system_reset}};
         slow_tick <= slow_rise && !in_stop;
         pre_tick <= pit_tick && !in_stop;
         clock_output_pin <= next_co && !system_reset && !in_stop;
         power_mode_indicator_pins <= mode;
         tod_alarm_irq <= alm_flag;
         pit_irq <= pit_flag && pit_ie;
         pready <= psel && !penable;
         pslverr <= psel && !penable && !known;
         prdata <= (psel && !penable && !pwrite && known) ? rdmux : 32'h0;
      end
   end
   wire unused_ok = rd_acc;
endmodule

// ### cpmrt_top_tb.sv
// Testbench: APB, mode and reset scenarios for the clock and power mode block
`timescale 1ns/100ps
module cpmrt_top_tb;
   import cpmrt_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b1;
   logic clk_en = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic lvr = 1'b0;
   logic extr = 1'b0;
   logic por = 1'b0;
   logic [1:0] lp_instr = 2'b00;
   logic lp_instr_valid = 1'b0;
   logic irq_any = 1'b0;
   logic [7:0] peri_irq = 8'h00;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, fast, slow, cpu_clk_en, slow_tick, pre_tick;
   logic clock_output_pin, system_reset, tod_alarm_irq, pit_irq;
   logic [7:0] peri_clk_en;
   logic [1:0] pins;
   int miscompares = 0;
   int checks_done = 0;
   int clk_seen;
   cpmrt_top #(.NPERI(8)) uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fast_reference_clock(fast),
      .slow_crystal_clock(slow), .low_voltage_reset(lvr), .external_reset(extr),
      .power_on_reset(por), .lp_instr(lp_instr), .lp_instr_valid(lp_instr_valid),
      .irq_any(irq_any), .peri_irq(peri_irq), .cpu_clk_en(cpu_clk_en),
      .peri_clk_en(peri_clk_en), .slow_tick(slow_tick), .pre_tick(pre_tick),
      .clock_output_pin(clock_output_pin), .power_mode_indicator_pins(pins),
      .system_reset(system_reset), .tod_alarm_irq(tod_alarm_irq), .pit_irq(pit_irq));
   cpmrt_ext_dev u_ext (.pclk(pclk), .fast_reference_clock(fast), .slow_crystal_clock(slow),
      .clock_output_pin(clock_output_pin), .clk_seen(clk_seen));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic wrap_up;
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // APB master: request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      chk(pready, 1'b1);
      if (pready !== 1'b1) wrap_up();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wait_pins(input logic [1:0] m, input int lim);
      for (int n = 0; n < lim && pins !== m; n++) @(posedge pclk);
      chk(pins, m);
      if (pins !== m) wrap_up();
   endtask
   // Mode entry: one request pulse, bench holds lp_instr afterwards
   task automatic enter(input logic [1:0] m);
      lp_instr <= m;
      lp_instr_valid <= 1'b1;
      @(posedge pclk);
      lp_instr_valid <= 1'b0;
      wait_pins(m, 20);
      chk(cpu_clk_en, 1'b0);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_clock_output_pin;
      int e;
      for (int s = 0; s < 3; s++) begin
         apb(1'b1, CPMRT_CTRL, 32'(s));
         repeat (4) @(posedge pclk);
         e = clk_seen;
         repeat (62) @(posedge pclk);
         chk((clk_seen - e) / 10, (s == 1) ? 3 : 2 * (s / 2));
      end
      extr <= 1'b1;
      @(posedge pclk);
      extr <= 1'b0;
      repeat (4) @(posedge pclk);
      e = clk_seen;
      repeat (62) @(posedge pclk);
      chk(clk_seen - e, 0);
      $display("clock_output_pin test done");
   endtask
   task automatic t_reset_src;
      apb(1'b1, CPMRT_RSTS, 32'hf);
      for (int i = 0; i < 3; i++) begin
         {por, extr, lvr} <= 3'h1 << i;
         @(posedge pclk);
         {por, extr, lvr} <= 3'h0;
         @(posedge pclk);
         apb(1'b0, CPMRT_RSTS, 32'h0);
         chk(rd, 32'h1 << i);
         apb(1'b1, CPMRT_RSTS, 32'hf);
      end
      $display("reset source test done");
   endtask
   task automatic t_regs;
      apb(1'b0, 8'h34, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      apb(1'b0, CPMRT_WCTL, 32'h0);
      chk(rd & 32'h13f, 32'h3f);
      apb(1'b1, CPMRT_WCTL, 32'h125);
      apb(1'b1, CPMRT_WSRV, {16'h0, CPMRT_WKEY1});
      apb(1'b1, CPMRT_WSRV, {16'h0, CPMRT_WKEY2});
      apb(1'b0, CPMRT_WCTL, 32'h0);
      chk(rd & 32'h3f0000, 32'h250000);
      $display("register test done");
   endtask
   // Five fraction steps of 384 cycles pass while halted in wait
   task automatic t_wait_tod;
      apb(1'b1, CPMRT_TSEC, 32'h1234_5678);
      enter(CPMRT_WAIT);
      repeat (1920) @(posedge pclk);
      chk(cpu_clk_en, 1'b0);
      irq_any <= 1'b1;
      wait_pins(CPMRT_RUN, 10);
      irq_any <= 1'b0;
      chk(cpu_clk_en, 1'b1);
      apb(1'b0, CPMRT_TFRC, 32'h0);
      chk(rd >= 5 && rd <= 6, 1'b1);
      apb(1'b0, CPMRT_TSEC, 32'h0);
      chk(rd, 32'h1234_5678);
      $display("wait test done");
   endtask
   task automatic t_doze;
      apb(1'b1, CPMRT_PERI, 32'hff);
      apb(1'b1, CPMRT_DOZE, 32'h05);
      enter(CPMRT_DOZE_M);
      chk(peri_clk_en, 8'h05);
      peri_irq <= 8'h02;
      repeat (8) @(posedge pclk);
      chk(pins, CPMRT_DOZE_M);
      peri_irq <= 8'h04;
      wait_pins(CPMRT_RUN, 10);
      peri_irq <= 8'h00;
      chk(peri_clk_en, 8'hff);
      apb(1'b1, CPMRT_PERI, 32'h5a);
      @(posedge pclk);
      chk({cpu_clk_en, peri_clk_en}, 9'h15a);
      $display("doze test done");
   endtask
   task automatic t_stop;
      int e;
      apb(1'b1, CPMRT_CTRL, 32'h2);
      apb(1'b1, CPMRT_PMOD, 32'h40);
      apb(1'b1, CPMRT_PCTL, 32'hd);
      enter(CPMRT_STOP);
      e = clk_seen;
      wait_pins(CPMRT_RUN, 2000);
      chk(clk_seen - e < 2, 1'b1);
      chk(pit_irq, 1'b1);
      apb(1'b1, CPMRT_PCTL, 32'h10);
      apb(1'b0, CPMRT_PCTL, 32'h0);
      chk({pit_irq, rd[4]}, 2'b00);
      $display("stop test done");
   endtask
   initial begin
      forever #4 pclk = ~pclk;
   end
   initial begin
      // A real falling edge, so the asynchronous reset branch runs at time zero
      presetn <= 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_clock_output_pin();
      t_reset_src();
      t_regs();
      t_wait_tod();
      t_doze();
      t_stop();
      wrap_up();
   end
endmodule
